// file: inc/cpt_regs.vh
`ifndef CPT_REGS_VH
`define CPT_REGS_VH

// register selectors on the byte-wide access port
`define CPT_SEL_TSC 3'h0
`define CPT_SEL_CNT_HI 3'h1
`define CPT_SEL_CNT_LO 3'h2
`define CPT_SEL_MOD_HI 3'h3
`define CPT_SEL_MOD_LO 3'h4
`define CPT_SEL_CSC 3'h5
`define CPT_SEL_CV_HI 3'h6
`define CPT_SEL_CV_LO 3'h7

// timer_status_control fields
`define CPT_TSC_RST 8'h00
`define CPT_TSC_CMS_BIT 5
`define CPT_TSC_EN_BIT 3
`define CPT_TSC_RD_MASK 8'h28

// channel_status_control fields
`define CPT_CSC_RST 8'h00
`define CPT_CSC_ELA_BIT 2
`define CPT_CSC_RD_MASK 8'h04

// 16-bit value constants
`define CPT_ZERO16 16'h0000
`define CPT_ONE16 16'h0001
`define CPT_MAX16 16'hFFFF
`define CPT_SIGN_BIT 15

// byte-pair buffer state
`define CPT_BOTH_BYTES 2'h3
`define CPT_NO_BYTES 2'h0

`endif

// file: hw/cpt_center_pwm.v
`timescale 1ns/1ps
`include "cpt_regs.vh"

// Notes on behaviour
// - center mode counts up to modulo, down to zero
// - compare sets width, modulo sets period
// - compare zero or negative gives 0% duty
// - positive compare above modulo gives 100% duty
// - edge mode modulo zero runs free, wraps
// - edge level select a sets output polarity
// - select clear: up match low, down high
// - modulo and compare byte writes land in buffer registers
// - status, counter, modulo, channel registers provided
// - counter write clears it; reads harmless
module cpt_center_pwm #(
   parameter CNT_W = 16
)
(
   // clock and reset
   input wire clk,
   input wire srst,
   // byte register access port
   input wire [2:0] reg_sel,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // pwm pin
   output wire pwm_out,
   output wire pwm_oe
);

   localparam ST_UP = 2'b01;
   localparam ST_DOWN = 2'b10;

   reg [7:0] tsc_ff;
   reg [7:0] csc_ff;
   reg [CNT_W-1:0] cnt_ff;
   reg [CNT_W-1:0] mod_ff;
   reg [CNT_W-1:0] cv_ff;
   reg [CNT_W-1:0] mod_buf_ff;
   reg [CNT_W-1:0] cv_buf_ff;
   reg [1:0] mod_seen_ff;
   reg [1:0] cv_seen_ff;
   reg [1:0] dir_ff;
   reg pwm_ff;
   reg [CNT_W-1:0] nxt_cnt;
   reg [1:0] nxt_dir;
   reg nxt_pwm;

   wire enabled = tsc_ff[`CPT_TSC_EN_BIT];
   wire center = tsc_ff[`CPT_TSC_CMS_BIT];
   wire ela = csc_ff[`CPT_CSC_ELA_BIT];
   wire cv_neg = cv_ff[`CPT_SIGN_BIT];
   wire cv_zero = (cv_ff == `CPT_ZERO16);
   wire cnt_wr = reg_wr && (reg_sel == `CPT_SEL_CNT_HI || reg_sel == `CPT_SEL_CNT_LO);

   // period boundary: counter about to restart its cycle
   wire boundary = center ? (dir_ff == ST_DOWN && cnt_ff == `CPT_ONE16)
                          : (cnt_ff == mod_ff || mod_ff == `CPT_ZERO16 && cnt_ff == `CPT_MAX16);
   wire load = enabled && boundary;

   function [CNT_W-1:0] put_byte;
      input [CNT_W-1:0] old;
      input hi;
      input [7:0] b;
      begin
         put_byte = hi ? {b, old[7:0]} : {old[CNT_W-1:8], b};
      end
   endfunction

   // counter and direction
   always @*
   begin
      nxt_cnt = cnt_ff;
      nxt_dir = dir_ff;
      if (center)
      begin
         case (dir_ff)
            ST_UP:
            begin
               if (cnt_ff >= mod_ff)
               begin
                  nxt_dir = ST_DOWN;
                  nxt_cnt = cnt_ff - `CPT_ONE16;
               end
               else
                  nxt_cnt = cnt_ff + `CPT_ONE16;
            end
            default:
            begin
               if (cnt_ff == `CPT_ZERO16)
               begin
                  nxt_dir = ST_UP;
                  nxt_cnt = cnt_ff + `CPT_ONE16;
               end
               else
                  nxt_cnt = cnt_ff - `CPT_ONE16;
            end
         endcase
      end
      else
      begin
         nxt_dir = ST_UP;
         // modulo zero lets it wrap at all ones
         if (mod_ff != `CPT_ZERO16 && cnt_ff == mod_ff)
            nxt_cnt = `CPT_ZERO16;
         else
            nxt_cnt = cnt_ff + `CPT_ONE16;
      end
   end

   // output: compare match sets level by direction and polarity
   always @*
   begin
      nxt_pwm = pwm_ff;
      if (!center)
         nxt_pwm = ela;
      else if (cv_zero || cv_neg)
         nxt_pwm = ela;
      else if (cv_ff > mod_ff)
         nxt_pwm = ~ela;
      // turnaround at modulo acts as down match, so cv equal to modulo is full width
      else if (cnt_ff == cv_ff && dir_ff == ST_UP && cnt_ff != mod_ff)
         nxt_pwm = ela;
      else if (cnt_ff == cv_ff)
         nxt_pwm = ~ela;
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         tsc_ff <= `CPT_TSC_RST;
         csc_ff <= `CPT_CSC_RST;
         cnt_ff <= `CPT_ZERO16;
         mod_ff <= `CPT_ZERO16;
         cv_ff <= `CPT_ZERO16;
         mod_buf_ff <= `CPT_ZERO16;
         cv_buf_ff <= `CPT_ZERO16;
         mod_seen_ff <= `CPT_NO_BYTES;
         cv_seen_ff <= `CPT_NO_BYTES;
         dir_ff <= ST_UP;
         pwm_ff <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_sel == `CPT_SEL_TSC)
            tsc_ff <= reg_wdata & `CPT_TSC_RD_MASK;
         if (reg_wr && reg_sel == `CPT_SEL_CSC)
            csc_ff <= reg_wdata & `CPT_CSC_RD_MASK;
         if (cnt_wr)
         begin
            cnt_ff <= `CPT_ZERO16;
            dir_ff <= ST_UP;
         end
         else if (enabled)
         begin
            cnt_ff <= nxt_cnt;
            dir_ff <= nxt_dir;
         end
         if (enabled)
            pwm_ff <= nxt_pwm;
         // modulo buffer: a load at a boundary beats a same-cycle byte write
         if (load && mod_seen_ff == `CPT_BOTH_BYTES)
         begin
            mod_ff <= mod_buf_ff;
            mod_seen_ff <= `CPT_NO_BYTES;
         end
         else if (reg_wr && reg_sel == `CPT_SEL_MOD_HI)
         begin
            mod_buf_ff <= put_byte(mod_buf_ff, 1'b1, reg_wdata);
            mod_seen_ff <= mod_seen_ff | 2'b10;
         end
         else if (reg_wr && reg_sel == `CPT_SEL_MOD_LO)
         begin
            mod_buf_ff <= put_byte(mod_buf_ff, 1'b0, reg_wdata);
            mod_seen_ff <= mod_seen_ff | 2'b01;
         end
         else if (!enabled && mod_seen_ff == `CPT_BOTH_BYTES)
         begin
            // stopped timer has no boundary, so load at once
            mod_ff <= mod_buf_ff;
            mod_seen_ff <= `CPT_NO_BYTES;
         end
         if (load && cv_seen_ff == `CPT_BOTH_BYTES)
         begin
            cv_ff <= cv_buf_ff;
            cv_seen_ff <= `CPT_NO_BYTES;
         end
         else if (reg_wr && reg_sel == `CPT_SEL_CV_HI)
         begin
            cv_buf_ff <= put_byte(cv_buf_ff, 1'b1, reg_wdata);
            cv_seen_ff <= cv_seen_ff | 2'b10;
         end
         else if (reg_wr && reg_sel == `CPT_SEL_CV_LO)
         begin
            cv_buf_ff <= put_byte(cv_buf_ff, 1'b0, reg_wdata);
            cv_seen_ff <= cv_seen_ff | 2'b01;
         end
         else if (!enabled && cv_seen_ff == `CPT_BOTH_BYTES)
         begin
            cv_ff <= cv_buf_ff;
            cv_seen_ff <= `CPT_NO_BYTES;
         end
      end
   end

   // read mux; reading never touches the counter
   always @*
   begin
      if (reg_sel == `CPT_SEL_TSC)
         reg_rdata = tsc_ff;
      else if (reg_sel == `CPT_SEL_CNT_HI)
         reg_rdata = cnt_ff[15:8];
      else if (reg_sel == `CPT_SEL_CNT_LO)
         reg_rdata = cnt_ff[7:0];
      else if (reg_sel == `CPT_SEL_MOD_HI)
         reg_rdata = mod_ff[15:8];
      else if (reg_sel == `CPT_SEL_MOD_LO)
         reg_rdata = mod_ff[7:0];
      else if (reg_sel == `CPT_SEL_CSC)
         reg_rdata = csc_ff;
      else if (reg_sel == `CPT_SEL_CV_HI)
         reg_rdata = cv_ff[15:8];
      else
         reg_rdata = cv_ff[7:0];
   end

   assign pwm_out = pwm_ff;
   // pin driven only while the timer runs in center mode
   assign pwm_oe = enabled && center;

endmodule

// file: tb/cpt_center_pwm_chk.sv
`timescale 1ns/1ps
module cpt_chk (
   // clock and reset
   input wire clk,
   input wire srst,
   // register port
   input wire [2:0] reg_sel,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   // pin
   input wire pwm_out,
   input wire pwm_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   AST_RST_IDLE: assert property ($fell(srst) |-> reg_rdata == 8'h00 && !pwm_out && !pwm_oe)
      else $error("not idle");
   AST_TSC_MASK: assert property (reg_wr && reg_sel == 3'h0 ##1 reg_sel == 3'h0
      |-> reg_rdata == ($past(reg_wdata) & 8'h28)) else $error("tsc");
   AST_CSC_MASK: assert property (reg_wr && reg_sel == 3'h5 ##1 reg_sel == 3'h5
      |-> reg_rdata == ($past(reg_wdata) & 8'h04)) else $error("csc");
   AST_CNT_LO_CLR: assert property (reg_wr && reg_sel == 3'h2 ##1 reg_sel == 3'h2
      |-> reg_rdata == 8'h00) else $error("cnt lo");
   AST_CNT_HI_CLR: assert property (reg_wr && reg_sel == 3'h1 ##1 reg_sel == 3'h1
      |-> reg_rdata == 8'h00) else $error("cnt hi");
   AST_OE: assert property (reg_sel == 3'h0 |-> pwm_oe == (reg_rdata[5] & reg_rdata[3]))
      else $error("oe");
   AST_TSC_HOLD: assert property (!reg_wr && reg_sel == 3'h0 ##1 reg_sel == 3'h0
      |-> $stable(reg_rdata)) else $error("tsc moved");
   AST_PWM_FROZEN: assert property (!pwm_oe && !reg_wr && !$past(reg_wr) |=> $stable(pwm_out))
      else $error("pwm moved");
endmodule
bind cpt_center_pwm cpt_chk u_chk (.clk(clk), .srst(srst), .reg_sel(reg_sel), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pwm_out(pwm_out), .pwm_oe(pwm_oe));

// file: tb/cpt_load.sv
`timescale 1ns/1ps
module cpt_load (
   // clock
   input wire clk,
   // pin and window
   input wire pin,
   input wire pin_oe,
   input wire clr,
   // high time seen
   output reg [7:0] high_cnt
);
   // an undriven pin counts as low
   always @(posedge clk)
   begin
      if (clr)
         high_cnt <= 8'h00;
      else if (pin_oe && pin)
         high_cnt <= high_cnt + 8'h01;
   end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
   reg clk = 1'b0;
   reg srst = 1'b1;
   reg [2:0] sel = 3'h0;
   reg wr_en = 1'b0;
   reg [7:0] wd = 8'h00;
   reg clr = 1'b1;
   wire [7:0] rd;
   wire pwm;
   wire oe;
   wire [7:0] hi_n;
   integer err_count = 0;
   integer n_checks = 0;
   always #12.5 clk = ~clk;
   cpt_center_pwm u_cpt_center_pwm (.clk(clk), .srst(srst), .reg_sel(sel), .reg_wr(wr_en),
      .reg_wdata(wd), .reg_rdata(rd), .pwm_out(pwm), .pwm_oe(oe));
   cpt_load u_cpt_load (.clk(clk), .pin(pwm), .pin_oe(oe), .clr(clr), .high_cnt(hi_n));
   task chk(input [31:0] nm, input [7:0] seen, input [7:0] exp);
   begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task wr(input [2:0] s, input [7:0] d);
   begin
      @(negedge clk);
      sel = s;
      wd = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
   end
   endtask
   task setup(input [15:0] m, input [15:0] v, input [7:0] c);
   begin
      srst = 1'b1;
      repeat (8) @(negedge clk);
      srst = 1'b0;
      wr(3'h3, m[15:8]);
      wr(3'h4, m[7:0]);
      wr(3'h6, v[15:8]);
      wr(3'h7, v[7:0]);
      wr(3'h5, c);
   end
   endtask
   // two periods of four-count modulo
   task duty(input [7:0] exp);
   begin
      repeat (16) @(negedge clk);
      clr = 1'b0;
      repeat (16) @(negedge clk);
      clr = 1'b1;
      chk("duty", hi_n, exp);
   end
   endtask
   task run(input [15:0] v, input [7:0] c, input [7:0] exp);
   begin
      setup(16'h0004, v, c);
      wr(3'h0, 8'h28);
      duty(exp);
   end
   endtask
   task t_regs;
   begin
      setup(16'h0004, 16'h0002, 8'hFF);
      chk("csc ", rd, 8'h04);
      wr(3'h0, 8'hFF);
      chk("tsc ", rd, 8'h28);
      chk("oe  ", {7'h00, oe}, 8'h01);
      wr(3'h2, 8'h55);
      chk("cntl", rd, 8'h00);
      wr(3'h1, 8'h55);
      chk("cnth", rd, 8'h00);
      @(negedge clk);
   end
   endtask
   task t_duty;
   begin
      run(16'h0003, 8'h00, 8'h0C);
      run(16'h0004, 8'h00, 8'h10);
      run(16'h0001, 8'h04, 8'h0C);
      run(16'h0000, 8'h00, 8'h00);
      run(16'h8003, 8'h00, 8'h00);
      run(16'h0000, 8'h04, 8'h10);
      run(16'h0005, 8'h00, 8'h10);
      run(16'h0005, 8'h04, 8'h00);
   end
   endtask
   task t_buf;
   begin
      run(16'h0001, 8'h00, 8'h04);
      wr(3'h7, 8'h03);
      duty(8'h04);
      wr(3'h6, 8'h00);
      sel = 3'h7;
      #1;
      chk("cvbf", rd, 8'h01);
      duty(8'h0C);
      chk("cvld", rd, 8'h03);
   end
   endtask
   task t_free;
   begin
      setup(16'h0000, 16'h0000, 8'h00);
      wr(3'h0, 8'h08);
      wr(3'h2, 8'hA5);
      repeat (65535) @(negedge clk);
      chk("cntl", rd, 8'hFF);
      sel = 3'h1;
      #1;
      chk("cnth", rd, 8'hFF);
      chk("oe  ", {7'h00, oe}, 8'h00);
      @(negedge clk);
      chk("wrap", rd, 8'h00);
   end
   endtask
   task end_of_test;
   begin
      if (err_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   initial
   begin
      t_regs;
      t_duty;
      t_buf;
      t_free;
      end_of_test;
   end
endmodule
